// ### tcd_pkg.sv
package tcd_pkg;

    // ------------------------------------------------------------------
    // Register map (byte addresses)
    // ------------------------------------------------------------------
    localparam logic [7:0] TCD_OFF_CTRL = 8'h00;
    localparam logic [7:0] TCD_OFF_COUNT = 8'h04;
    localparam logic [7:0] TCD_OFF_DELAY = 8'h08;
    localparam logic [7:0] TCD_OFF_STATUS = 8'h0c;
    localparam logic [7:0] TCD_OFF_IRQ_STAT = 8'h10;
    localparam logic [7:0] TCD_OFF_IRQ_MASK = 8'h14;
    localparam logic [7:0] TCD_OFF_ERROR = 8'h18;
    localparam logic [7:0] TCD_OFF_REMAIN = 8'h1c;

    // ------------------------------------------------------------------
    // Control register fields (write-one pulses except SCAN and FUNC)
    // ------------------------------------------------------------------
    localparam int TCD_CTRL_ARM = 0;
    localparam int TCD_CTRL_ABORT = 1;
    localparam int TCD_CTRL_CONFIG = 2;
    localparam int TCD_CTRL_SCAN = 3;
    localparam int TCD_CTRL_FUNC_LO = 4;
    localparam int TCD_CTRL_CNT_MIN = 8;
    localparam int TCD_CTRL_CNT_MAX = 9;
    localparam int TCD_CTRL_DLY_MIN = 10;
    localparam int TCD_CTRL_DLY_MAX = 11;
    localparam int TCD_CTRL_AUTO_ON = 12;
    localparam int TCD_CTRL_AUTO_OFF = 13;

    // Interrupt bits
    localparam int TCD_IRQ_DONE = 0;
    localparam int TCD_IRQ_PASS = 1;
    localparam int TCD_IRQ_ERR = 2;
    localparam int TCD_IRQ_W = 3;

    // ------------------------------------------------------------------
    // Limits, resets and timing
    // ------------------------------------------------------------------
    localparam int TCD_CNT_W = 24;
    localparam logic [23:0] TCD_COUNT_MIN = 24'h000001;
    localparam logic [23:0] TCD_COUNT_MAX = 24'hffffff;
    localparam logic [23:0] TCD_DELAY_ZERO = 24'h000000;
    localparam logic [23:0] TCD_DELAY_MAX = 24'hffffff;
    localparam logic [23:0] TCD_DELAY_AC_US = 24'h07a120;
    localparam logic [15:0] TCD_ERR_OUT_OF_MEM = 16'h03e8;
    localparam int TCD_CLK_MHZ = 100;
    localparam int TCD_TICK_NS = 1000;
    localparam int TCD_TICK_CYC = TCD_TICK_NS * TCD_CLK_MHZ / 1000;

    typedef enum logic [1:0] {
        TCD_FN_DCV = 2'h0,
        TCD_FN_ACV = 2'h1,
        TCD_FN_RES = 2'h2,
        TCD_FN_RES4 = 2'h3
    } tcd_func_t;

    typedef enum logic [3:0] {
        TCD_IDLE = 4'b0001,
        TCD_WAIT = 4'b0010,
        TCD_DELAY = 4'b0100,
        TCD_TRIG = 4'b1000
    } tcd_state_t;

    typedef struct packed {
        logic [TCD_CNT_W-1:0] count;
        logic [TCD_CNT_W-1:0] delay_us;
        logic auto_dly;
        logic scan;
        tcd_func_t func;
    } tcd_cfg_t;

endpackage

// ### tcd_sequencer.sv
`timescale 1ns/10ps
// Summary of operation
// - Arm goes to wait, trigger to triggered, idle when all are done or on abort.
// - Scanning, each list pass needs a new trigger; count is the passes.
// - Stand-alone, the programmed number of triggers is taken before idle.
// - Trigger count is 1 to 16777215; min and max selections load these.
// - A configure operation resets the trigger count to one.
// - The largest count logs error 1000, yet readings may still stream out.
// - Each trigger is followed by the delay, then the first measurement.
// - Delay is 0 to 16.777215 s; the max selection loads the upper limit.
// - Min delay is zero for DC volts and ohms, 0.5 s for AC volts.
// - Auto delay is zero for DC volts and ohms, 0.5 s for AC volts.
// - Writing an explicit delay value clears automatic delay.
// - A configure operation turns automatic delay on.
module tcd_sequencer import tcd_pkg::*; #(
    parameter int TICK_CYC = TCD_TICK_CYC
) (
    input wire logic core_clk_in,
    input wire logic rstn_in,
    input wire logic [7:0] s_axi_awaddr_in,
    input wire logic s_axi_awvalid_in,
    output logic s_axi_awready_out,
    input wire logic [31:0] s_axi_wdata_in,
    input wire logic [3:0] s_axi_wstrb_in,
    input wire logic s_axi_wvalid_in,
    output logic s_axi_wready_out,
    output logic [1:0] s_axi_bresp_out,
    output logic s_axi_bvalid_out,
    input wire logic s_axi_bready_in,
    input wire logic [7:0] s_axi_araddr_in,
    input wire logic s_axi_arvalid_in,
    output logic s_axi_arready_out,
    output logic [31:0] s_axi_rdata_out,
    output logic [1:0] s_axi_rresp_out,
    output logic s_axi_rvalid_out,
    input wire logic s_axi_rready_in,
    input wire logic trig_in,
    output logic meas_start_out,
    input wire logic meas_done_in,
    output logic [1:0] state_out,
    output logic irq_out
);

    // ------------------------------------------------------------------
    // Bus write path
    // ------------------------------------------------------------------
    logic [7:0] awaddr_q;
    logic aw_have_q;
    logic [31:0] wdata_q;
    logic [3:0] wstrb_q;
    logic w_have_q;
    logic wr_fire;
    logic [31:0] wmask;

    assign wr_fire = aw_have_q && w_have_q && !s_axi_bvalid_out;
    assign wmask = {{8{wstrb_q[3]}}, {8{wstrb_q[2]}},
                    {8{wstrb_q[1]}}, {8{wstrb_q[0]}}};

    always_ff @(posedge core_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            awaddr_q <= 8'h00;
            aw_have_q <= 1'b0;
            s_axi_awready_out <= 1'b0;
        end else begin
            s_axi_awready_out <= !aw_have_q && !s_axi_awready_out;
            if (s_axi_awvalid_in && s_axi_awready_out) begin
                awaddr_q <= s_axi_awaddr_in;
                aw_have_q <= 1'b1;
                s_axi_awready_out <= 1'b0;
            end else if (wr_fire) begin
                aw_have_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge core_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            wdata_q <= 32'h00000000;
            wstrb_q <= 4'h0;
            w_have_q <= 1'b0;
            s_axi_wready_out <= 1'b0;
        end else begin
            s_axi_wready_out <= !w_have_q && !s_axi_wready_out;
            if (s_axi_wvalid_in && s_axi_wready_out) begin
                wdata_q <= s_axi_wdata_in;
                wstrb_q <= s_axi_wstrb_in;
                w_have_q <= 1'b1;
                s_axi_wready_out <= 1'b0;
            end else if (wr_fire) begin
                w_have_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge core_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            s_axi_bvalid_out <= 1'b0;
            s_axi_bresp_out <= 2'h0;
        end else if (wr_fire) begin
            s_axi_bvalid_out <= 1'b1;
            s_axi_bresp_out <= (awaddr_q > TCD_OFF_REMAIN ||
                                awaddr_q[1:0] != 2'h0) ? 2'h2 : 2'h0;
        end else if (s_axi_bready_in) begin
            s_axi_bvalid_out <= 1'b0;
        end
    end

    // Decoded write pulses; strobes gate the low byte lanes used
    logic wr_ctrl, wr_count, wr_delay, wr_istat, wr_imask;
    logic [31:0] wval;
    assign wval = wdata_q & wmask;
    assign wr_ctrl = wr_fire && awaddr_q == TCD_OFF_CTRL;
    assign wr_count = wr_fire && awaddr_q == TCD_OFF_COUNT;
    assign wr_delay = wr_fire && awaddr_q == TCD_OFF_DELAY;
    assign wr_istat = wr_fire && awaddr_q == TCD_OFF_IRQ_STAT;
    assign wr_imask = wr_fire && awaddr_q == TCD_OFF_IRQ_MASK;

    logic do_arm, do_abort, do_cfg;
    assign do_arm = wr_ctrl && wval[TCD_CTRL_ARM];
    assign do_abort = wr_ctrl && wval[TCD_CTRL_ABORT];
    assign do_cfg = wr_ctrl && wval[TCD_CTRL_CONFIG];

    // ------------------------------------------------------------------
    // Configuration
    // ------------------------------------------------------------------
    tcd_cfg_t cfg_q;
    tcd_state_t state_q;
    logic err_set;

    // Writes and limit selections only take effect outside a run
    always_ff @(posedge core_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            cfg_q <= '{count: TCD_COUNT_MIN, delay_us: TCD_DELAY_ZERO,
                       auto_dly: 1'b1, scan: 1'b0, func: TCD_FN_DCV};
        end else if (state_q == TCD_IDLE) begin
            if (wr_ctrl) begin
                cfg_q.scan <= wval[TCD_CTRL_SCAN];
                cfg_q.func <= tcd_func_t'(wval[TCD_CTRL_FUNC_LO +: 2]);
                if (wval[TCD_CTRL_CNT_MIN])
                    cfg_q.count <= TCD_COUNT_MIN;
                else if (wval[TCD_CTRL_CNT_MAX])
                    cfg_q.count <= TCD_COUNT_MAX;
                if (wval[TCD_CTRL_DLY_MIN]) begin
                    cfg_q.delay_us <= (wval[TCD_CTRL_FUNC_LO +: 2] ==
                        TCD_FN_ACV) ? TCD_DELAY_AC_US : TCD_DELAY_ZERO;
                    cfg_q.auto_dly <= 1'b0;
                end else if (wval[TCD_CTRL_DLY_MAX]) begin
                    cfg_q.delay_us <= TCD_DELAY_MAX;
                    cfg_q.auto_dly <= 1'b0;
                end
                if (wval[TCD_CTRL_AUTO_ON])
                    cfg_q.auto_dly <= 1'b1;
                else if (wval[TCD_CTRL_AUTO_OFF])
                    cfg_q.auto_dly <= 1'b0;
                if (wval[TCD_CTRL_CONFIG]) begin
                    cfg_q.count <= TCD_COUNT_MIN;
                    cfg_q.auto_dly <= 1'b1;
                end
            end else if (wr_count) begin
                // Zero is out of range and is raised to the minimum
                cfg_q.count <= (wval[23:0] == 24'h000000) ?
                    TCD_COUNT_MIN : wval[23:0];
            end else if (wr_delay) begin
                cfg_q.delay_us <= wval[23:0];
                cfg_q.auto_dly <= 1'b0;
            end
        end
    end

    // Out-of-memory error: logged, the run still proceeds
    logic count_max_req;
    assign count_max_req = state_q == TCD_IDLE &&
        ((wr_count && wval[23:0] == TCD_COUNT_MAX) ||
         (wr_ctrl && wval[TCD_CTRL_CNT_MAX] && !wval[TCD_CTRL_CNT_MIN] &&
          !wval[TCD_CTRL_CONFIG]));
    assign err_set = count_max_req;

    logic [15:0] err_code_q;
    always_ff @(posedge core_clk_in or negedge rstn_in) begin
        if (!rstn_in)
            err_code_q <= 16'h0000;
        else if (err_set)
            err_code_q <= TCD_ERR_OUT_OF_MEM;
        else if (do_cfg)
            err_code_q <= 16'h0000;
    end

    // Effective delay: automatic choice follows the function
    logic [TCD_CNT_W-1:0] eff_delay;
    assign eff_delay = !cfg_q.auto_dly ? cfg_q.delay_us :
        (cfg_q.func == TCD_FN_ACV) ? TCD_DELAY_AC_US : TCD_DELAY_ZERO;

    // ------------------------------------------------------------------
    // Microsecond timebase
    // ------------------------------------------------------------------
    logic [15:0] tick_cnt_q;
    logic tick;
    assign tick = tick_cnt_q == 16'(TICK_CYC - 1);
    always_ff @(posedge core_clk_in or negedge rstn_in) begin
        if (!rstn_in)
            tick_cnt_q <= 16'h0000;
        else if (state_q != TCD_DELAY || tick)
            tick_cnt_q <= 16'h0000;
        else
            tick_cnt_q <= tick_cnt_q + 16'h0001;
    end

    // ------------------------------------------------------------------
    // Trigger sequencer
    // ------------------------------------------------------------------
    logic [TCD_CNT_W-1:0] trig_left_q;
    logic [TCD_CNT_W-1:0] dly_left_q;
    logic pass_done, run_done;
    assign pass_done = state_q == TCD_TRIG && meas_done_in;
    assign run_done = pass_done && trig_left_q == 24'h000001;

    always_ff @(posedge core_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            state_q <= TCD_IDLE;
            trig_left_q <= TCD_COUNT_MIN;
            dly_left_q <= TCD_DELAY_ZERO;
        end else if (do_abort) begin
            state_q <= TCD_IDLE;
        end else begin
            case (state_q)
                TCD_IDLE: begin
                    if (do_arm) begin
                        trig_left_q <= cfg_q.count;
                        state_q <= TCD_WAIT;
                    end
                end
                TCD_WAIT: begin
                    // Each burst or pass needs its own trigger
                    if (trig_in) begin
                        dly_left_q <= eff_delay;
                        state_q <= TCD_DELAY;
                    end
                end
                TCD_DELAY: begin
                    if (dly_left_q == 24'h000000)
                        state_q <= TCD_TRIG;
                    else if (tick)
                        dly_left_q <= dly_left_q - 24'h000001;
                end
                TCD_TRIG: begin
                    if (meas_done_in) begin
                        trig_left_q <= trig_left_q - 24'h000001;
                        state_q <= run_done ? TCD_IDLE : TCD_WAIT;
                    end
                end
                default: state_q <= TCD_IDLE;
            endcase
        end
    end

    always_ff @(posedge core_clk_in or negedge rstn_in) begin
        if (!rstn_in)
            meas_start_out <= 1'b0;
        else
            meas_start_out <= state_q == TCD_DELAY &&
                dly_left_q == 24'h000000 && !do_abort;
    end

    always_ff @(posedge core_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            state_out <= 2'h0;
        end else begin
            case (state_q)
                TCD_WAIT: state_out <= 2'h1;
                TCD_DELAY, TCD_TRIG: state_out <= 2'h2;
                default: state_out <= 2'h0;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Interrupts: set wins over a write-one clear
    // ------------------------------------------------------------------
    logic [TCD_IRQ_W-1:0] irq_stat_q, irq_mask_q, irq_ev;
    assign irq_ev = {err_set, pass_done, run_done};

    always_ff @(posedge core_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            irq_stat_q <= '0;
            irq_mask_q <= '0;
        end else begin
            irq_stat_q <= (irq_stat_q & ~(wr_istat ?
                wval[TCD_IRQ_W-1:0] : '0)) | irq_ev;
            if (wr_imask)
                irq_mask_q <= wval[TCD_IRQ_W-1:0];
        end
    end

    always_ff @(posedge core_clk_in or negedge rstn_in) begin
        if (!rstn_in)
            irq_out <= 1'b0;
        else
            irq_out <= |(irq_stat_q & irq_mask_q);
    end

    // ------------------------------------------------------------------
    // Bus read path
    // ------------------------------------------------------------------
    logic [31:0] rd_val;
    logic rd_bad;
    always_comb begin
        rd_val = 32'h00000000;
        rd_bad = 1'b0;
        case (s_axi_araddr_in)
            TCD_OFF_CTRL: rd_val = {26'h0, cfg_q.func, cfg_q.scan, 3'h0};
            TCD_OFF_COUNT: rd_val = {8'h00, cfg_q.count};
            TCD_OFF_DELAY: rd_val = {7'h00, cfg_q.auto_dly, eff_delay};
            TCD_OFF_STATUS: rd_val = {28'h0, state_q};
            TCD_OFF_IRQ_STAT: rd_val = {29'h0, irq_stat_q};
            TCD_OFF_IRQ_MASK: rd_val = {29'h0, irq_mask_q};
            TCD_OFF_ERROR: rd_val = {16'h0000, err_code_q};
            TCD_OFF_REMAIN: rd_val = {8'h00, trig_left_q};
            default: rd_bad = 1'b1;
        endcase
    end

    always_ff @(posedge core_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            s_axi_arready_out <= 1'b0;
            s_axi_rvalid_out <= 1'b0;
            s_axi_rdata_out <= 32'h00000000;
            s_axi_rresp_out <= 2'h0;
        end else begin
            s_axi_arready_out <= !s_axi_rvalid_out && !s_axi_arready_out;
            if (s_axi_arvalid_in && s_axi_arready_out) begin
                s_axi_arready_out <= 1'b0;
                s_axi_rvalid_out <= 1'b1;
                s_axi_rdata_out <= rd_val;
                s_axi_rresp_out <= rd_bad ? 2'h2 : 2'h0;
            end else if (s_axi_rvalid_out && s_axi_rready_in) begin
                s_axi_rvalid_out <= 1'b0;
            end
        end
    end

endmodule // tcd_sequencer

// ### tcd_properties.sv
`timescale 1ns/10ps
// ----------------------------------------
// Port-level checks of the sequencer
// ----------------------------------------
module tcd_properties import tcd_pkg::*; #(
    parameter int TICK_CYC = TCD_TICK_CYC
) (
    input wire logic core_clk_in,
    input wire logic rstn_in,
    input wire logic s_axi_awready_out,
    input wire logic s_axi_bvalid_out,
    input wire logic s_axi_bready_in,
    input wire logic s_axi_rvalid_out,
    input wire logic s_axi_rready_in,
    input wire logic [31:0] s_axi_rdata_out,
    input wire logic trig_in,
    input wire logic meas_start_out,
    input wire logic meas_done_in,
    input wire logic [1:0] state_out
);
    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (!rstn_in);

    property p_idle_exit;
        state_out == 2'h0 |=> state_out != 2'h2;
    endproperty
    a_idle_exit: assert property (p_idle_exit)
        else $error("idle jumped to triggered");
    property p_trig_take;
        trig_in ##1 state_out == 2'h1 |=> state_out == 2'h2;
    endproperty
    a_trig_take: assert property (p_trig_take)
        else $error("trigger not taken");
    // Only a new trigger may start a burst or a pass
    property p_no_trig;
        !trig_in ##1 state_out == 2'h1 |=> state_out != 2'h2;
    endproperty
    a_no_trig: assert property (p_no_trig)
        else $error("triggered without trigger");
    property p_start_trig;
        meas_start_out |-> state_out == 2'h2;
    endproperty
    a_start_trig: assert property (p_start_trig)
        else $error("start outside triggered state");
    property p_start_pulse;
        meas_start_out |=> !meas_start_out;
    endproperty
    a_start_pulse: assert property (p_start_pulse)
        else $error("start longer than one cycle");
    property p_done_leave;
        state_out == 2'h2 && meas_done_in |-> ##2 state_out != 2'h2;
    endproperty
    a_done_leave: assert property (p_done_leave)
        else $error("done did not end pass");
    property p_b_hold;
        s_axi_bvalid_out && !s_axi_bready_in |=> s_axi_bvalid_out;
    endproperty
    a_b_hold: assert property (p_b_hold)
        else $error("bvalid dropped early");
    property p_r_hold;
        s_axi_rvalid_out && !s_axi_rready_in
            |=> s_axi_rvalid_out && $stable(s_axi_rdata_out);
    endproperty
    a_r_hold: assert property (p_r_hold)
        else $error("read answer not held");
    c_start: cover property (meas_start_out);
endmodule // tcd_properties

// ### tcd_partner.sv
`timescale 1ns/10ps
// ----------------------------------------
// Trigger source and measurement engine
// ----------------------------------------
module tcd_partner (
    input wire logic core_clk_in,
    input wire logic rstn_in,
    input wire logic fire_in,
    input wire logic [3:0] lat_in,
    input wire logic meas_start_in,
    output logic trig_out,
    output logic meas_done_out,
    output logic [7:0] n_start_out,
    output logic [15:0] gap_out
);
    logic [15:0] age_q;
    logic [3:0] wait_q;
    logic busy_q;
    // Gap is counted from the cycle the trigger is seen
    always_ff @(posedge core_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            trig_out <= 1'b0;
            meas_done_out <= 1'b0;
            n_start_out <= 8'h00;
            gap_out <= 16'h0000;
            age_q <= 16'h0000;
            wait_q <= 4'h0;
            busy_q <= 1'b0;
        end else begin
            trig_out <= fire_in;
            meas_done_out <= 1'b0;
            age_q <= trig_out ? 16'h0000 : age_q + 16'h0001;
            if (meas_start_in) begin
                n_start_out <= n_start_out + 8'h01;
                gap_out <= age_q;
                busy_q <= 1'b1;
                wait_q <= lat_in;
            end else if (busy_q) begin
                if (wait_q == 4'h0) begin
                    meas_done_out <= 1'b1;
                    busy_q <= 1'b0;
                end else begin
                    wait_q <= wait_q - 4'h1;
                end
            end
        end
    end
endmodule // tcd_partner

// ### testbench.sv
`timescale 1ns/10ps
module testbench;
    import tcd_pkg::*;
    localparam int TICK_CYC = 2;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [7:0] awaddr = 8'h00;
    logic [7:0] araddr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic arvalid = 1'b0, rready = 1'b0, fire = 1'b0;
    logic [3:0] lat = 4'h0;
    logic awready, wready, bvalid, arready, rvalid;
    logic meas_start, meas_done, trig, irq;
    logic [1:0] bresp, rresp, state;
    logic [31:0] rdata;
    logic [7:0] n_start;
    logic [15:0] gap;
    logic [65:0] exp_q[$];
    logic [65:0] e_v;
    int n_errors = 0;
    int tests_run = 0;
    int seed = 15;
    int nr, dl, base;

    tcd_sequencer #(.TICK_CYC(TICK_CYC)) dut (.core_clk_in(clk),
        .rstn_in(rst_n), .s_axi_awaddr_in(awaddr),
        .s_axi_awvalid_in(awvalid), .s_axi_awready_out(awready),
        .s_axi_wdata_in(wdata), .s_axi_wstrb_in(4'hf),
        .s_axi_wvalid_in(wvalid), .s_axi_wready_out(wready),
        .s_axi_bresp_out(bresp), .s_axi_bvalid_out(bvalid),
        .s_axi_bready_in(bready), .s_axi_araddr_in(araddr),
        .s_axi_arvalid_in(arvalid), .s_axi_arready_out(arready),
        .s_axi_rdata_out(rdata), .s_axi_rresp_out(rresp),
        .s_axi_rvalid_out(rvalid), .s_axi_rready_in(rready),
        .trig_in(trig), .meas_start_out(meas_start),
        .meas_done_in(meas_done), .state_out(state), .irq_out(irq));
    tcd_partner u_far (.core_clk_in(clk), .rstn_in(rst_n),
        .fire_in(fire), .lat_in(lat), .meas_start_in(meas_start),
        .trig_out(trig), .meas_done_out(meas_done),
        .n_start_out(n_start), .gap_out(gap));

    initial forever #5 clk = ~clk;

    task end_sim;
        $display("errors %0d checks %0d", n_errors, tests_run);
        if (n_errors == 0 && tests_run > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    task chk(input logic ok, input string msg);
        tests_run++;
        if (ok !== 1'b1) begin
            n_errors++;
            $display("CHECK FAILED %0t %s", $time, msg);
        end
    endtask
    // Waits until a handshake pair is seen high before an edge
    task automatic wt(ref logic v, ref logic r);
        int n;
        n = 0;
        do begin
            @(negedge clk);
            n++;
        end while (!(v && r) && n < 300);
        if (n >= 300) begin
            chk(1'b0, "handshake timeout");
            end_sim;
        end
        @(posedge clk);
    endtask
    task wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        fork
            begin wt(awvalid, awready); awvalid <= 1'b0; end
            begin wt(wvalid, wready); wvalid <= 1'b0; end
        join
        wt(bready, bvalid);
        bready <= 1'b0;
    endtask
    task rd(input logic [7:0] a, input logic [31:0] d,
            input logic [31:0] m, input logic [1:0] rs);
        exp_q.push_back({rs, m, d});
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        wt(arvalid, arready);
        arvalid <= 1'b0;
        wt(rready, rvalid);
        rready <= 1'b0;
    endtask
    task wst(input logic [1:0] s);
        int n;
        n = 0;
        while (state !== s && n < 300) begin
            @(negedge clk);
            n++;
        end
        chk(state === s, "state wait");
        if (state !== s)
            end_sim;
    endtask
    task trg(input int d);
        int n;
        n = 0;
        base = n_start;
        @(posedge clk);
        fire <= 1'b1;
        lat <= 4'($random(seed));
        @(posedge clk);
        fire <= 1'b0;
        while (n_start == base && n < 300) begin
            @(negedge clk);
            n++;
        end
        if (n >= 300) begin
            chk(1'b0, "no start");
            end_sim;
        end
        chk(gap + TICK_CYC >= d * TICK_CYC, "delay short");
        chk(gap <= d * TICK_CYC + 4, "delay long");
    endtask

    always @(negedge clk) begin
        if (rvalid && rready) begin
            e_v = exp_q.pop_front();
            tests_run++;
            if ((rdata & e_v[63:32]) !== (e_v[31:0] & e_v[63:32])
                || rresp !== e_v[65:64]) begin
                n_errors++;
                $display("CHECK FAILED %0t read %h", $time, rdata);
            end
        end
        if (bvalid && bready) begin
            tests_run++;
            if (bresp !== 2'h0) begin
                n_errors++;
                $display("CHECK FAILED %0t write resp %h", $time, bresp);
            end
        end
    end

    initial begin
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        rd(TCD_OFF_CTRL, 32'h0, 32'h3f, 2'h0);
        rd(TCD_OFF_COUNT, 32'h1, '1, 2'h0);
        rd(TCD_OFF_DELAY, 32'h01000000, '1, 2'h0);
        rd(TCD_OFF_STATUS, 32'h1, 32'hf, 2'h0);
        $display("test reset values done");
        wr(TCD_OFF_CTRL, 32'h200);
        rd(TCD_OFF_COUNT, 32'hffffff, '1, 2'h0);
        rd(TCD_OFF_ERROR, 32'h3e8, 32'hffff, 2'h0);
        wr(TCD_OFF_CTRL, 32'h100);
        rd(TCD_OFF_COUNT, 32'h1, '1, 2'h0);
        wr(TCD_OFF_COUNT, 32'h0);
        rd(TCD_OFF_COUNT, 32'h1, '1, 2'h0);
        wr(TCD_OFF_COUNT, 32'h7);
        wr(TCD_OFF_DELAY, 32'h5);
        rd(TCD_OFF_DELAY, 32'h5, 32'h01ffffff, 2'h0);
        wr(TCD_OFF_CTRL, 32'h4);
        rd(TCD_OFF_COUNT, 32'h1, '1, 2'h0);
        rd(TCD_OFF_DELAY, 32'h01000000, 32'h01ffffff, 2'h0);
        $display("test count limits done");
        // AC volts is chosen in the same write as the delay selection
        for (int f = 0; f < 4; f++) begin
            dl = (f == 1) ? 32'(TCD_DELAY_AC_US) : 0;
            wr(TCD_OFF_CTRL, (f << 4) | 32'h400);
            rd(TCD_OFF_DELAY, dl, 32'hffffff, 2'h0);
            wr(TCD_OFF_CTRL, (f << 4) | 32'h1000);
            rd(TCD_OFF_DELAY, dl | 32'h01000000, '1, 2'h0);
        end
        wr(TCD_OFF_CTRL, 32'h2000);
        wr(TCD_OFF_CTRL, 32'h800);
        rd(TCD_OFF_DELAY, 32'hffffff, 32'h01ffffff, 2'h0);
        rd(8'h40, 32'h0, '1, 2'h2);
        $display("test delay selections done");
        nr = 2 + ($unsigned($random(seed)) % 3);
        dl = $unsigned($random(seed)) % 4;
        wr(TCD_OFF_IRQ_MASK, 32'h0);
        wr(TCD_OFF_CTRL, 32'h0);
        wr(TCD_OFF_COUNT, nr);
        wr(TCD_OFF_DELAY, dl);
        wr(TCD_OFF_CTRL, 32'h1);
        for (int i = 0; i < nr; i++) begin
            wst(2'h1);
            trg(dl);
        end
        wst(2'h0);
        chk(n_start === 8'(nr), "burst count");
        rd(TCD_OFF_IRQ_STAT, 32'h3, 32'h3, 2'h0);
        chk(irq === 1'b0, "masked irq");
        wr(TCD_OFF_IRQ_MASK, 32'h3);
        repeat (3) @(negedge clk);
        chk(irq === 1'b1, "irq raised");
        wr(TCD_OFF_IRQ_STAT, 32'h3);
        repeat (3) @(negedge clk);
        chk(irq === 1'b0, "irq cleared");
        $display("test stand-alone run done");
        base = n_start;
        wr(TCD_OFF_COUNT, 32'h2);
        wr(TCD_OFF_DELAY, 32'h0);
        wr(TCD_OFF_CTRL, 32'h8);
        wr(TCD_OFF_CTRL, 32'h9);
        wst(2'h1);
        repeat (40) @(negedge clk);
        chk(n_start === 8'(base) && state === 2'h1, "scan no trig");
        trg(0);
        wst(2'h1);
        trg(0);
        wst(2'h0);
        chk(n_start === 8'(nr + 2), "scan passes");
        $display("test scan run done");
        wr(TCD_OFF_CTRL, 32'h1);
        wst(2'h1);
        rd(TCD_OFF_REMAIN, 32'h2, 32'hffffff, 2'h0);
        rd(TCD_OFF_STATUS, 32'h2, 32'hf, 2'h0);
        wr(TCD_OFF_CTRL, 32'h2);
        wst(2'h0);
        chk(n_start === 8'(nr + 2), "abort start");
        $display("test abort done");
        end_sim;
    end
endmodule // testbench

bind tcd_sequencer tcd_properties #(.TICK_CYC(TICK_CYC)) u_chk (
    .core_clk_in, .rstn_in, .s_axi_awready_out, .s_axi_bvalid_out,
    .s_axi_bready_in, .s_axi_rvalid_out, .s_axi_rready_in,
    .s_axi_rdata_out, .trig_in, .meas_start_out, .meas_done_in,
    .state_out);
